//--- design/lcr_regs.sv
// Functional notes
// (RQ1) Auto all-ones per channel during signal loss
// (RQ2) Global bit inserts alarm signal on loss
// (RQ3) Protection on while disable bit zero
// (RQ4) Coding bit: zero line code, one AMI
// (RQ5) Depth bit: 32 or 64 bit store
// (RQ6) Bandwidth bit picks low or high corner
// (RQ7) Path 01 transmit, 11 receive, else unused
// (RQ8) Pointer picks channel for template accesses
// (RQ9) Template code selects pulse shape per channel
// (RQ10) Output control bit sets driver high impedance
// (RQ11) Status shows alarm detected per channel
// (RQ12) Mask bit allows alarm interrupt for channel
// (RQ13) Event set on any masked status transition
// (RQ14) Status read clears events; events reset zero
// (RQ15) Power-up or 00 selects primary bank
// (RQ16) Pointer AA maps addresses to expanded bank
// (RQ17) Force clear: transmit pin chooses rail mode
// (RQ18) Force set with recovery on: single rail
// (RQ19) Per-channel coding only single rail, recovery on
// (RQ20) Bit n belongs to channel n
// (RQ21) Host writes zero to reserved bits
`timescale 1ns/1ps
`default_nettype none
`include "lcr_params.svh"

module lcr_regs
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Host register port
  input var lcr_host_req_type host_i,
  output logic [7:0] rdata_o,
  // Line pins and per-channel detector levels
  input wire logic [7:0] signal_loss_i,
  input wire logic [7:0] alarm_detect_i,
  input wire logic [7:0] negative_data_transmit_pin_i,
  // Settings held elsewhere in the expanded bank
  input wire logic [7:0] recovery_disable_bit_i,
  input wire logic [7:0] channel_ami_select_i,
  // Line control outputs
  output logic [7:0] send_all_ones_o,
  output logic [7:0] insert_ais_o,
  output logic [7:0] driver_hiz_o,
  output logic [23:0] template_code_o,
  output logic [7:0] single_rail_o,
  output logic [7:0] ami_coding_o,
  output var lcr_global_out_type global_o,
  output logic bank_expanded_o
);

  lcr_state_type r;
  lcr_state_type n;
  lcr_pins_type pins_raw;
  lcr_pins_type pins;

  logic expanded;
  logic wr_prim;
  logic wr_exp;
  logic rd_prim;
  logic rd_exp;
  logic status_read;
  logic [7:0] rd_mux;
  logic [7:0] edges;

  assign pins_raw.loss = signal_loss_i;
  assign pins_raw.alarm_indication_status = alarm_detect_i;
  assign pins_raw.tdn = negative_data_transmit_pin_i;

  lcr_sync lcr_sync_inst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pins_i(pins_raw),
    .pins_o(pins)
  );

  // Anything but the expanded code keeps the primary bank
  assign expanded = r.bank_exp; // [RQ15] [RQ16]
  assign wr_prim = host_i.wr && !expanded;
  assign wr_exp = host_i.wr && expanded;
  assign rd_prim = host_i.rd && !expanded;
  assign rd_exp = host_i.rd && expanded;
  assign status_read = rd_prim && (host_i.addr == `LCR_OFS_AIS_STATUS);
  assign edges = pins.alarm_indication_status ^ r.ais_status;

  // Read data mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (rd_exp)
    begin
      if (host_i.addr == `LCR_XOFS_SINGLE_RAIL)
      begin
        rd_mux = r.single_force;
      end
      else if (host_i.addr == `LCR_OFS_BANK_POINTER)
      begin
        rd_mux = r.bank;
      end
    end
    else
    begin
      unique case (host_i.addr)
        `LCR_OFS_AUTO_ALL_ONES: rd_mux = r.auto_all_ones;
        `LCR_OFS_GLOBAL_CFG: rd_mux = r.global_configuration;
        `LCR_OFS_TMPL_POINTER: rd_mux = {5'h00, r.tmpl_ptr};
        `LCR_OFS_TMPL_SELECT: rd_mux = {5'h00, r.tmpl[r.tmpl_ptr]}; // [RQ8]
        `LCR_OFS_DRIVER_HIZ: rd_mux = r.hiz;
        `LCR_OFS_AIS_STATUS: rd_mux = r.ais_status; // [RQ11]
        `LCR_OFS_AIS_MASK: rd_mux = r.ais_mask;
        `LCR_OFS_AIS_EVENT: rd_mux = r.ais_event;
        `LCR_OFS_BANK_POINTER: rd_mux = r.bank;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    n = r;

    // Bank pointer lives at the same address in both banks
    if (host_i.wr && host_i.addr == `LCR_OFS_BANK_POINTER)
    begin
      n.bank = host_i.wdata; // [RQ15] [RQ16]
    end
    // Decoded here so the bank flag leaves the block from a flop
    n.bank_exp = (n.bank == `LCR_BANK_EXPANDED); // [RQ15] [RQ16]

    if (wr_exp && host_i.addr == `LCR_XOFS_SINGLE_RAIL)
    begin
      n.single_force = host_i.wdata;
    end

    if (wr_prim)
    begin
      unique case (host_i.addr)
        `LCR_OFS_AUTO_ALL_ONES: n.auto_all_ones = host_i.wdata;
        // Reserved bits are dropped so they always read zero
        `LCR_OFS_GLOBAL_CFG: n.global_configuration = host_i.wdata & `LCR_GCF_USED_MASK;
        `LCR_OFS_TMPL_POINTER: n.tmpl_ptr = host_i.wdata[2:0]; // [RQ8]
        `LCR_OFS_TMPL_SELECT: n.tmpl[r.tmpl_ptr] = host_i.wdata[2:0]; // [RQ8]
        `LCR_OFS_DRIVER_HIZ: n.hiz = host_i.wdata; // [RQ10]
        `LCR_OFS_AIS_MASK: n.ais_mask = host_i.wdata; // [RQ12]
        default: n.ais_mask = r.ais_mask;
      endcase
    end

    // Status follows the synchronised detector level
    n.ais_status = pins.alarm_indication_status; // [RQ11]

    // Per channel: a masked transition sets, a status read clears,
    // and a set in the clearing cycle is kept
    for (int i = 0; i < 8; i++)
    begin
      if (status_read)
      begin
        n.ais_event[i] = 1'b0; // [RQ14]
      end
      if (edges[i] && r.ais_mask[i])
      begin
        n.ais_event[i] = 1'b1; // [RQ13] [RQ20]
      end
      n.send_all_ones[i] = r.auto_all_ones[i] && pins.loss[i]; // [RQ1]
      n.insert_ais[i] = r.global_configuration[`LCR_GCF_AIS_INSERT] && pins.loss[i]; // [RQ2]
      // A force with recovery disabled is not a legal single-rail
      // request, so the pin keeps control in that case
      if (r.single_force[i] && !recovery_disable_bit_i[i])
      begin
        n.single_rail[i] = 1'b1; // [RQ18]
      end
      else
      begin
        n.single_rail[i] = pins.tdn[i]; // [RQ17]
      end
      if (n.single_rail[i] && !recovery_disable_bit_i[i])
      begin
        n.ami[i] = channel_ami_select_i[i]; // [RQ19]
      end
      else
      begin
        n.ami[i] = r.global_configuration[`LCR_GCF_CODING]; // [RQ4]
      end
    end

    n.glob.short_protect_en = !r.global_configuration[`LCR_GCF_PROTECT_OFF]; // [RQ3]
    n.glob.ami_global = r.global_configuration[`LCR_GCF_CODING]; // [RQ4]
    n.glob.depth64 = r.global_configuration[`LCR_GCF_DEPTH]; // [RQ5]
    n.glob.bw_high = r.global_configuration[`LCR_GCF_BANDWIDTH]; // [RQ6]
    n.glob.path_transmit = (r.global_configuration[`LCR_GCF_PATH_HI:`LCR_GCF_PATH_LO]
                            == `LCR_PATH_TRANSMIT); // [RQ7]
    n.glob.path_receive = (r.global_configuration[`LCR_GCF_PATH_HI:`LCR_GCF_PATH_LO]
                           == `LCR_PATH_RECEIVE); // [RQ7]

    if (host_i.rd)
    begin
      n.rdata = rd_mux;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.glob.short_protect_en <= 1'b1; // [RQ3]
    end
    else
    begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign send_all_ones_o = r.send_all_ones;
  assign insert_ais_o = r.insert_ais;
  assign driver_hiz_o = r.hiz;
  assign template_code_o = r.tmpl; // [RQ9]
  assign single_rail_o = r.single_rail;
  assign ami_coding_o = r.ami;
  assign global_o = r.glob;
  assign bank_expanded_o = r.bank_exp;

endmodule

`default_nettype wire

//--- design/lcr_params.svh
`ifndef LCR_PARAMS_SVH
`define LCR_PARAMS_SVH

// Primary bank offsets
`define LCR_OFS_AUTO_ALL_ONES 8'h0e
`define LCR_OFS_GLOBAL_CFG 8'h0f
`define LCR_OFS_TMPL_POINTER 8'h10
`define LCR_OFS_TMPL_SELECT 8'h11
`define LCR_OFS_DRIVER_HIZ 8'h12
`define LCR_OFS_AIS_STATUS 8'h13
`define LCR_OFS_AIS_MASK 8'h14
`define LCR_OFS_AIS_EVENT 8'h15
`define LCR_OFS_BANK_POINTER 8'h1f

// Expanded bank offsets
`define LCR_XOFS_SINGLE_RAIL 8'h00

// Bank pointer codes
`define LCR_BANK_PRIMARY 8'h00
`define LCR_BANK_EXPANDED 8'haa

// Global configuration field positions
`define LCR_GCF_AIS_INSERT 6
`define LCR_GCF_PROTECT_OFF 5
`define LCR_GCF_CODING 4
`define LCR_GCF_DEPTH 3
`define LCR_GCF_BANDWIDTH 2
`define LCR_GCF_PATH_HI 1
`define LCR_GCF_PATH_LO 0
`define LCR_GCF_USED_MASK 8'h7f

// Jitter path codes
`define LCR_PATH_TRANSMIT 2'h1
`define LCR_PATH_RECEIVE 2'h3

// Template pointer and code widths
`define LCR_PTR_MASK 8'h07
`define LCR_TMPL_MASK 8'h07

// Reset values
`define LCR_RST_BYTE 8'h00
`define LCR_RST_TMPL 3'h0

`endif

//--- design/lcr_pkg.sv
`default_nettype none
package lcr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcr_host_req_type;

  typedef struct packed {
    logic [7:0] loss;
    logic [7:0] alarm_indication_status;
    logic [7:0] tdn;
  } lcr_pins_type;

  typedef struct packed {
    logic short_protect_en;
    logic ami_global;
    logic depth64;
    logic bw_high;
    logic path_transmit;
    logic path_receive;
  } lcr_global_out_type;

  typedef struct packed {
    lcr_pins_type s1;
    lcr_pins_type s2;
  } lcr_sync_state_type;

  typedef struct packed {
    logic [7:0] auto_all_ones;
    logic [7:0] global_configuration;
    logic [2:0] tmpl_ptr;
    logic [7:0][2:0] tmpl;
    logic [7:0] hiz;
    logic [7:0] ais_status;
    logic [7:0] ais_mask;
    logic [7:0] ais_event;
    logic [7:0] bank;
    logic bank_exp;
    logic [7:0] single_force;
    logic [7:0] rdata;
    logic [7:0] send_all_ones;
    logic [7:0] insert_ais;
    logic [7:0] single_rail;
    logic [7:0] ami;
    lcr_global_out_type glob;
  } lcr_state_type;

endpackage
`default_nettype wire

//--- design/lcr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module lcr_sync
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pins from outside the clock domain
  input var lcr_pins_type pins_i,
  // Synchronised levels
  output var lcr_pins_type pins_o
);

  lcr_sync_state_type r;
  lcr_sync_state_type n;

  // First stage feeds only the second stage
  always_comb
  begin
    n.s1 = pins_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign pins_o = r.s2;

endmodule

`default_nettype wire

//--- tb/lcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model
  import lcr_pkg::*;
(
  // Host port
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output var lcr_host_req_type host_o
);
  initial host_o = '0;
  // One strobe per call; held over exactly one rising edge
  task automatic access(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clock_i);
    host_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock_i);
    q = rdata_i;
    host_o = '0;
  endtask
endmodule
`default_nettype wire

//--- tb/lcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lcr_regs_asserts
  import lcr_pkg::*;
(
  // Clock, reset, host
  input wire logic clock_i,
  input wire logic rst_i,
  input var lcr_host_req_type host_i,
  input wire logic [7:0] rdata_o,
  // Pins
  input wire logic [7:0] signal_loss_i,
  input wire logic [7:0] negative_data_transmit_pin_i,
  input wire logic [7:0] recovery_disable_bit_i,
  // Outputs
  input wire logic [7:0] send_all_ones_o,
  input wire logic [7:0] insert_ais_o,
  input wire logic [7:0] driver_hiz_o,
  input wire logic [7:0] single_rail_o,
  input wire logic [7:0] ami_coding_o,
  input var lcr_global_out_type global_o,
  input wire logic bank_expanded_o
);
  logic [7:0] wd1_reg;
  logic [7:0] wd2_reg;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Global outputs settle two edges after the write, driver_hiz_o after one
  always_ff @(posedge clock_i)
  begin
    wd1_reg <= host_i.wdata;
    wd2_reg <= wd1_reg;
  end
  sequence s_pwr(a);
    host_i.wr && host_i.addr == a && !bank_expanded_o;
  endsequence
  property p_quiet;
    (signal_loss_i == 8'h00) [*3] |=>
      (send_all_ones_o | insert_ais_o) == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("line action without loss");
  property p_gcf;
    s_pwr(8'h0f) |=> ##1 global_o == {~wd2_reg[5], wd2_reg[4:2],
      wd2_reg[1:0] == 2'h1, wd2_reg[1:0] == 2'h3};
  endproperty
  a_gcf: assert property (p_gcf)
    else $error("global outputs wrong");
  property p_hiz;
    s_pwr(8'h12) ##1 !host_i.wr |=> driver_hiz_o == wd2_reg;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("driver high-z wrong");
  property p_xrd;
    host_i.rd && host_i.addr == 8'h0e && bank_expanded_o |=>
      rdata_o == 8'h00;
  endproperty
  a_xrd: assert property (p_xrd)
    else $error("expanded read not remapped");
  property p_bank_on;
    host_i.wr && host_i.addr == 8'h1f && host_i.wdata == 8'haa |=>
      bank_expanded_o;
  endproperty
  a_bank_on: assert property (p_bank_on)
    else $error("expanded bank not selected");
  property p_bank_off;
    host_i.wr && host_i.addr == 8'h1f && host_i.wdata == 8'h00 |=>
      !bank_expanded_o;
  endproperty
  a_bank_off: assert property (p_bank_off)
    else $error("primary bank not selected");
  property p_rail;
    ($stable(negative_data_transmit_pin_i) &&
      recovery_disable_bit_i == 8'hff) [*3] |=>
      single_rail_o == $past(negative_data_transmit_pin_i);
  endproperty
  a_rail: assert property (p_rail)
    else $error("rail mode not from pin");
  property p_ami;
    (recovery_disable_bit_i == 8'hff && !host_i.wr) [*3] |=>
      ami_coding_o == {8{global_o.ami_global}};
  endproperty
  a_ami: assert property (p_ami)
    else $error("coding not global");
endmodule
bind lcr_regs lcr_regs_asserts lcr_regs_asserts_inst (
  .clock_i(clock_i), .rst_i(rst_i), .host_i(host_i), .rdata_o(rdata_o),
  .signal_loss_i(signal_loss_i), .send_all_ones_o(send_all_ones_o),
  .negative_data_transmit_pin_i(negative_data_transmit_pin_i),
  .recovery_disable_bit_i(recovery_disable_bit_i),
  .insert_ais_o(insert_ais_o), .driver_hiz_o(driver_hiz_o),
  .single_rail_o(single_rail_o), .ami_coding_o(ami_coding_o),
  .global_o(global_o), .bank_expanded_o(bank_expanded_o));
`default_nettype wire

//--- tb/tb_lcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lcr_regs
  import lcr_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  lcr_host_req_type host;
  logic [7:0] loss = '0, alarm = '0, pin = '0, rec = '0, csel = '0;
  logic [7:0] rdata, sao, ins, hiz, rail, ami, q;
  logic [23:0] tmpl;
  lcr_global_out_type glob;
  logic bexp;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  initial forever #25 clock_i = ~clock_i;
  lcr_regs lcr_regs_inst (.clock_i(clock_i), .rst_i(rst_i), .host_i(host),
    .rdata_o(rdata), .signal_loss_i(loss), .alarm_detect_i(alarm),
    .negative_data_transmit_pin_i(pin), .recovery_disable_bit_i(rec),
    .channel_ami_select_i(csel), .send_all_ones_o(sao),
    .insert_ais_o(ins), .driver_hiz_o(hiz), .template_code_o(tmpl),
    .single_rail_o(rail), .ami_coding_o(ami), .global_o(glob),
    .bank_expanded_o(bexp));
  lcr_host_model lcr_host_model_inst (.clock_i(clock_i), .rdata_i(rdata),
    .host_o(host));
  task automatic check(string n, logic [23:0] s, logic [23:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    lcr_host_model_inst.access(1'b1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    lcr_host_model_inst.access(1'b0, a, 8'h00, q);
    check("rdata", {16'h0, q}, {16'h0, e});
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic t_global();
    logic [7:0] w;
    logic [5:0] e;
    check("glob", {18'h0, glob}, 24'h20);
    rd(8'h15, 8'h00);
    rd(8'h1f, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      w = 8'(i * 37) & 8'h7f;
      wr(8'h0f, w);
      rd(8'h0f, w);
      e = {~w[5], w[4:2], w[1:0] == 2'h1, w[1:0] == 2'h3};
      check("glob", {18'h0, glob}, {18'h0, e});
      check("ami", {16'h0, ami}, {16'h0, {8{w[4]}}});
    end
    $display("global done");
  endtask
  task automatic t_template();
    logic [23:0] e;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, 8'(c));
      wr(8'h11, {5'h00, 3'(c + 3)});
      rd(8'h10, 8'(c));
      rd(8'h11, {5'h00, 3'(c + 3)});
      e[3 * c +: 3] = 3'(c + 3);
    end
    check("tmpl", tmpl, e);
    wr(8'h10, 8'h02);
    rd(8'h11, 8'h05);
    $display("template done");
  endtask
  task automatic t_line();
    wr(8'h12, 8'h5a);
    wr(8'h0e, 8'ha5);
    wr(8'h0f, 8'h40);
    loss = 8'h0f;
    idle(4);
    check("hiz", {16'h0, hiz}, 24'h5a);
    check("allones", {16'h0, sao}, 24'h05);
    check("insert", {16'h0, ins}, 24'h0f);
    loss = 8'h00;
    idle(4);
    check("quiet", {16'h0, sao | ins}, 24'h0);
    wr(8'h14, 8'h0f);
    rd(8'h14, 8'h0f);
    alarm = 8'h11;
    idle(4);
    rd(8'h15, 8'h01);
    rd(8'h13, 8'h11);
    rd(8'h15, 8'h00);
    alarm = 8'h00;
    idle(4);
    rd(8'h15, 8'h01);
    $display("line done");
  endtask
  task automatic t_bank();
    wr(8'h0f, 8'h00);
    wr(8'h1f, 8'haa);
    check("bank", {23'h0, bexp}, 24'h1);
    wr(8'h00, 8'h3c);
    wr(8'h0e, 8'hff);
    rd(8'h00, 8'h3c);
    rd(8'h0e, 8'h00);
    rd(8'h1f, 8'haa);
    rec = 8'h0f;
    pin = 8'h81;
    csel = 8'hff;
    idle(4);
    check("rail", {16'h0, rail}, 24'hb1);
    check("ami", {16'h0, ami}, 24'hb0);
    rec = 8'hff;
    idle(4);
    check("rail", {16'h0, rail}, 24'h81);
    check("ami", {16'h0, ami}, 24'h00);
    wr(8'h1f, 8'h00);
    check("bank", {23'h0, bexp}, 24'h0);
    rd(8'h0e, 8'ha5);
    rd(8'h16, 8'h00);
    $display("bank done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Tests need well under a thousand cycles
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      summarize();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    t_global();
    t_template();
    t_line();
    t_bank();
    summarize();
  end
endmodule
`default_nettype wire
